// ==== inc/etr_pkg.sv ====
// Constants, register map and state types of the elapsed-time and event recorder.
// Assumes a single 125 MHz clock and a byte-wide register port behind the serial framer.
package etr_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_NS = 8;
    localparam int TICK_MS = 250;
    localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
    localparam int FILTER_NS = 1000;
    localparam int FILT_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W = 25;
    localparam int FILT_W = 8;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h01;
    localparam logic [7:0] ADDR_PWA = 8'h02;
    localparam logic [7:0] ADDR_FEC = 8'h08;
    localparam logic [7:0] ADDR_ATC = 8'h0a;
    localparam logic [7:0] ADDR_CLIM = 8'h10;
    localparam logic [7:0] ADDR_TLIM = 8'h12;
    localparam logic [7:0] ADDR_CFG = 8'h16;
    localparam logic [7:0] ADDR_SPW = 8'h1a;
    localparam logic [7:0] ADDR_UMEM = 8'h20;
    localparam int UMEM_BYTES = 16;
    localparam logic [7:0] UNMAPPED_DATA = 8'hff;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int CMD_REL_BIT = 0;
    localparam int STAT_TIME_BIT = 0;
    localparam int STAT_CNT_BIT = 1;
    localparam int STAT_ACT_BIT = 2;
    localparam int CFG_POL_BIT = 0;
    localparam int CFG_CNT_EN_BIT = 1;
    localparam int CFG_TIME_EN_BIT = 2;
    localparam int CFG_W = 3;
    localparam logic [31:0] PWA_RESET = 32'hffffffff;
    localparam logic [31:0] SPW_RESET = 32'hffffffff;
    localparam logic [15:0] FEC_RESET = 16'h0000;
    localparam logic [31:0] ATC_RESET = 32'h00000000;
    localparam logic [15:0] CLIM_RESET = 16'h0000;
    localparam logic [31:0] TLIM_RESET = 32'h00000000;
    localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
    localparam logic [7:0] UMEM_RESET = 8'h00;

    typedef struct packed {
        logic act;
        logic [FILT_W-1:0] filt_cnt;
        logic [TICK_W-1:0] tick_cnt;
        logic [15:0] evt_vol;
        logic [15:0] evt_nv;
        logic [31:0] atc_vol;
        logic [31:0] atc_nv;
        logic [15:0] cnt_lim;
        logic [31:0] tim_lim;
        logic [CFG_W-1:0] cfg;
        logic [31:0] spw;
        logic [31:0] pwa;
        logic [31:0] spw_stage;
        logic [3:0] spw_mask;
        logic evt_dirty;
        logic atc_dirty;
        logic alert;
        logic [7:0] rdata;
        logic rvalid;
        logic rd_mem;
    } etr_state_t;

    typedef struct packed {
        logic [UMEM_BYTES-1:0][7:0] cells;
        logic [7:0] rdata;
    } etr_mem_state_t;

endpackage

// ==== inc/etr_mem_if.sv ====
// Port bundle between the register logic and the user memory.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface etr_mem_if;
    logic we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== rtl/etr_user_mem.sv ====
// Sixteen-byte user memory with registered read data.
// Assumes the controller applies write protection before raising we.
`timescale 1ns/1ps
module etr_user_mem
    import etr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    etr_mem_if.mem port
);
    etr_mem_state_t st_r;
    etr_mem_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (port.we) begin
            st_nxt.cells[port.waddr] = port.wdata;
        end
        st_nxt.rdata = st_r.cells[port.raddr];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '{cells: {UMEM_BYTES{UMEM_RESET}}, rdata: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port.rdata = st_r.rdata;
endmodule // etr_user_mem

// ==== rtl/etr_regs.sv ====
// Register file and counting logic of the elapsed-time and event recorder.
// Assumes a serial framer that presents one byte access per strobe and a stop strobe.
// Notes on behaviour
// - Sixteen user bytes, writable only with the correct password, else read-only.
// - Reads of unimplemented addresses return ff.
// - Password attempt and stored password bytes always read as zero.
// - Protected registers are writable only while attempt equals stored password.
// - Password attempt powers up all ones, matching the default stored password.
// - Command bit 0 reads zero; writing one releases the latched alert.
// - Status bit 2 shows filtered activity; status resets zero and is read-only.
// - Count flag is one while event count is at or above its limit.
// - Time flag is one while elapsed time is at or above its limit.
// - Event counter is 16 bits at 08h/09h, counting activity falling edges.
// - Event count reloads from stored copy at reset, rising edge, after write.
// - Each falling edge increments the event count by one, up to ffff.
// - After the increment the event count is copied to its stored copy.
// - Elapsed time is 32 bits at 0ah-0dh, low byte first, 250 ms units.
// - Elapsed time reloads from stored copy at reset, rising edge, after write.
// - While activity is high, elapsed time increments every 250 ms tick, up to ffffffff.
// - On a falling edge timing stops and elapsed time is stored.
// - Writes are ignored while activity is high; reads still work.
// - The event counter saturates at ffff.
// - An enabled limit flag latches the alert at its active polarity.
// - A zero limit disables its comparison, flag and alert.
`timescale 1ns/1ps
module etr_regs
    import etr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic activity,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_stb,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_stb,
    input wire logic reg_stop,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic alert_out,
    output logic alert_oe
);
    import etr_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
                                      input int bytes);
        in_range = (a >= base) && ({1'b0, a} < ({1'b0, base} + 9'(bytes)));
    endfunction

    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] i,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[8*i +: 8] = b;
        put_byte = r;
    endfunction

    function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] i);
        get_byte = w[8*i +: 8];
    endfunction

    etr_state_t st_r;
    etr_state_t st_nxt;
    etr_mem_if mif ();

    logic act_flip;
    logic rise;
    logic fall;
    logic unlocked;
    logic wr_ok;
    logic prot_ok;
    logic cnt_flag;
    logic tim_flag;
    logic release_req;
    logic [1:0] boff;

    // ---------------------------------------------------------------
    // Combinational decode
    // ---------------------------------------------------------------
    assign act_flip = (activity != st_r.act) && (st_r.filt_cnt == FILT_W'(FILT_CYC - 1));
    assign rise = act_flip && activity;
    assign fall = act_flip && !activity;
    assign unlocked = (st_r.pwa == st_r.spw);
    assign wr_ok = reg_wr_stb && !st_r.act;
    assign prot_ok = wr_ok && unlocked;
    assign cnt_flag = (st_r.cnt_lim != 16'h0000) && (st_r.evt_vol >= st_r.cnt_lim);
    assign tim_flag = (st_r.tim_lim != 32'h0) && (st_r.atc_vol >= st_r.tim_lim);
    assign release_req = wr_ok && (reg_addr == ADDR_CMD) && reg_wdata[CMD_REL_BIT];
    assign boff = reg_addr[1:0] - ADDR_PWA[1:0];

    assign mif.we = prot_ok && in_range(reg_addr, ADDR_UMEM, UMEM_BYTES);
    assign mif.waddr = reg_addr[3:0];
    assign mif.wdata = reg_wdata;
    assign mif.raddr = reg_addr[3:0];

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;

        // The input must differ for the whole filter time before it is accepted.
        if (activity == st_r.act) begin
            st_nxt.filt_cnt = '0;
        end else if (act_flip) begin
            st_nxt.act = activity;
            st_nxt.filt_cnt = '0;
        end else begin
            st_nxt.filt_cnt = st_r.filt_cnt + 1'b1;
        end

        if (rise) begin
            st_nxt.evt_vol = st_r.evt_nv;
            st_nxt.atc_vol = st_r.atc_nv;
            st_nxt.tick_cnt = '0;
        end else if (fall) begin
            if (st_r.evt_vol != 16'hffff) begin
                st_nxt.evt_vol = st_r.evt_vol + 16'h0001;
            end
            st_nxt.evt_nv = st_nxt.evt_vol;
            st_nxt.atc_nv = st_r.atc_vol;
        end else if (st_r.act) begin
            if (st_r.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
                st_nxt.tick_cnt = '0;
                if (st_r.atc_vol != 32'hffffffff) begin
                    st_nxt.atc_vol = st_r.atc_vol + 32'h1;
                end
            end else begin
                st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
            end
        end

        // ---------------------------------------------------------------
        // Register writes
        // ---------------------------------------------------------------
        if (wr_ok && in_range(reg_addr, ADDR_PWA, 4)) begin
            st_nxt.pwa = put_byte(st_r.pwa, boff, reg_wdata);
        end
        if (prot_ok) begin
            if (in_range(reg_addr, ADDR_FEC, 2)) begin
                st_nxt.evt_nv[8*reg_addr[0] +: 8] = reg_wdata;
                st_nxt.evt_dirty = 1'b1;
            end
            if (in_range(reg_addr, ADDR_ATC, 4)) begin
                st_nxt.atc_nv = put_byte(st_r.atc_nv, reg_addr[1:0] - ADDR_ATC[1:0],
                                         reg_wdata);
                st_nxt.atc_dirty = 1'b1;
            end
            if (in_range(reg_addr, ADDR_CLIM, 2)) begin
                st_nxt.cnt_lim[8*reg_addr[0] +: 8] = reg_wdata;
            end
            if (in_range(reg_addr, ADDR_TLIM, 4)) begin
                st_nxt.tim_lim = put_byte(st_r.tim_lim, reg_addr[1:0] - ADDR_TLIM[1:0],
                                          reg_wdata);
            end
            if (reg_addr == ADDR_CFG) begin
                st_nxt.cfg = reg_wdata[CFG_W-1:0];
            end
            if (in_range(reg_addr, ADDR_SPW, 4)) begin
                st_nxt.spw_stage = put_byte(st_r.spw_stage, reg_addr[1:0] - ADDR_SPW[1:0],
                                            reg_wdata);
                st_nxt.spw_mask[reg_addr[1:0] - ADDR_SPW[1:0]] = 1'b1;
            end
        end

        // A new stored password only takes effect when all four bytes came in one write.
        if (reg_stop) begin
            if (st_r.evt_dirty) begin
                st_nxt.evt_vol = st_r.evt_nv;
            end
            if (st_r.atc_dirty) begin
                st_nxt.atc_vol = st_r.atc_nv;
            end
            if (st_r.spw_mask == 4'hf) begin
                st_nxt.spw = st_r.spw_stage;
            end
            st_nxt.spw_mask = 4'h0;
            st_nxt.evt_dirty = 1'b0;
            st_nxt.atc_dirty = 1'b0;
        end

        // Setting wins over release, so a standing condition reasserts at once.
        st_nxt.alert = (st_r.alert && !release_req)
                     || (cnt_flag && st_r.cfg[CFG_CNT_EN_BIT])
                     || (tim_flag && st_r.cfg[CFG_TIME_EN_BIT]);

        // ---------------------------------------------------------------
        // Register reads
        // ---------------------------------------------------------------
        if (reg_rd_stb) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rd_mem = 1'b0;
            st_nxt.rdata = UNMAPPED_DATA;
            if (reg_addr == ADDR_CMD) begin
                st_nxt.rdata = 8'h00;
            end else if (reg_addr == ADDR_STAT) begin
                st_nxt.rdata = 8'h00;
                st_nxt.rdata[STAT_ACT_BIT] = st_r.act;
                st_nxt.rdata[STAT_CNT_BIT] = cnt_flag;
                st_nxt.rdata[STAT_TIME_BIT] = tim_flag;
            end else if (in_range(reg_addr, ADDR_PWA, 4) || in_range(reg_addr, ADDR_SPW, 4)) begin
                st_nxt.rdata = 8'h00;
            end else if (in_range(reg_addr, ADDR_FEC, 2)) begin
                // A live snapshot while active, the stored copy while idle.
                st_nxt.rdata = st_r.act ? st_r.evt_vol[8*reg_addr[0] +: 8]
                                        : st_r.evt_nv[8*reg_addr[0] +: 8];
            end else if (in_range(reg_addr, ADDR_ATC, 4)) begin
                st_nxt.rdata = get_byte(st_r.act ? st_r.atc_vol : st_r.atc_nv,
                                        reg_addr[1:0] - ADDR_ATC[1:0]);
            end else if (in_range(reg_addr, ADDR_CLIM, 2)) begin
                st_nxt.rdata = st_r.cnt_lim[8*reg_addr[0] +: 8];
            end else if (in_range(reg_addr, ADDR_TLIM, 4)) begin
                st_nxt.rdata = get_byte(st_r.tim_lim, reg_addr[1:0] - ADDR_TLIM[1:0]);
            end else if (reg_addr == ADDR_CFG) begin
                st_nxt.rdata = {5'h00, st_r.cfg};
            end else if (in_range(reg_addr, ADDR_UMEM, UMEM_BYTES)) begin
                st_nxt.rd_mem = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.pwa <= PWA_RESET;
            st_r.spw <= SPW_RESET;
            st_r.evt_nv <= FEC_RESET;
            st_r.evt_vol <= FEC_RESET;
            st_r.atc_nv <= ATC_RESET;
            st_r.atc_vol <= ATC_RESET;
            st_r.cnt_lim <= CLIM_RESET;
            st_r.tim_lim <= TLIM_RESET;
            st_r.cfg <= CFG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    etr_user_mem u_mem (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .port(mif.mem)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Open drain: polarity 0 pulls low when active, polarity 1 releases when active.
    assign alert_out = 1'b0;
    assign alert_oe = st_r.cfg[CFG_POL_BIT] ? !st_r.alert : st_r.alert;
    assign reg_rdata = st_r.rd_mem ? mif.rdata : st_r.rdata;
    assign reg_rvalid = st_r.rvalid;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_unmapped_ff: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_rd_stb && (reg_addr >= 8'h30) |=> reg_rvalid && reg_rdata == 8'hff)
        else $error("unmapped read not ff");
    chk_password_hidden: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_rd_stb && (in_range(reg_addr, ADDR_PWA, 4) || in_range(reg_addr, ADDR_SPW, 4))
        |=> reg_rdata == 8'h00)
        else $error("password byte disclosed");
    chk_cmd_reads_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_rd_stb && reg_addr == ADDR_CMD |=> reg_rdata == 8'h00)
        else $error("command read not zero");
    chk_status_value: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_rd_stb && reg_addr == ADDR_STAT
        |=> reg_rdata == {5'h00, $past(st_r.act), $past(cnt_flag), $past(tim_flag)})
        else $error("status read wrong");
    chk_locked_cfg: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_wr_stb && reg_addr == ADDR_CFG && st_r.pwa != st_r.spw |=> $stable(st_r.cfg))
        else $error("locked config changed");
    chk_active_ignore: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_wr_stb && st_r.act && !act_flip |=> $stable(st_r.pwa) && $stable(st_r.tim_lim))
        else $error("write taken while active");
    chk_user_lock: assert property (@(posedge sys_clk) disable iff (sys_rst)
        mif.we |-> !st_r.act && st_r.pwa == st_r.spw)
        else $error("user memory written while locked");
    chk_event_inc: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fall && st_r.evt_vol != 16'hffff
        |=> st_r.evt_vol == $past(st_r.evt_vol) + 16'h0001 && st_r.evt_nv == st_r.evt_vol)
        else $error("event count not stepped and stored");
    chk_event_sat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fall && st_r.evt_vol == 16'hffff |=> st_r.evt_nv == 16'hffff)
        else $error("event count rolled over");
    chk_rise_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rise |=> st_r.evt_vol == $past(st_r.evt_nv) && st_r.atc_vol == $past(st_r.atc_nv))
        else $error("counts not reloaded on rising edge");
    chk_fall_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fall |=> st_r.atc_nv == $past(st_r.atc_vol) && !st_r.act)
        else $error("elapsed time not stored on falling edge");
    chk_tick_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_r.act && !act_flip && st_r.tick_cnt == TICK_W'(TICK_CYCLES - 1)
        && st_r.atc_vol != 32'hffffffff && !reg_stop
        |=> st_r.atc_vol == $past(st_r.atc_vol) + 32'h1)
        else $error("elapsed time missed a tick");
    chk_zero_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_r.cnt_lim == 16'h0000 && st_r.tim_lim == 32'h0 && !st_r.alert |=> !st_r.alert)
        else $error("alert raised with limits off");
    chk_alert_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cnt_flag && st_r.cfg[CFG_CNT_EN_BIT] |=> st_r.alert ##1 (st_r.alert || release_req
        || $past(release_req)))
        else $error("alert not latched");
    chk_alert_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_r.alert && !release_req |=> st_r.alert)
        else $error("alert dropped without release");
endmodule // etr_regs

// ==== tb/etr_host.sv ====
// Host model of the byte register bus that sits behind the serial framer.
// Assumes it shares sys_clk with the recorder and drives on falling edges.
`timescale 1ns/1ps
module etr_host (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_stb,
    output logic [7:0] reg_wdata,
    output logic reg_rd_stb,
    output logic reg_stop,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        reg_stop = 1'b0;
    end
    // Address and data are inverted once released, so stale values never look valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_stb = 1'b1;
        @(negedge sys_clk);
        reg_wr_stb = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic stp();
        @(negedge sys_clk);
        reg_stop = 1'b1;
        @(negedge sys_clk);
        reg_stop = 1'b0;
    endtask
    // The answer comes exactly one edge after the request, so it is taken then.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd_stb = 1'b1;
        @(negedge sys_clk);
        reg_rd_stb = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule // etr_host

// ==== tb/tb_elapsed_time_event_recorder_regs.sv ====
// Self-checking bench for the recorder register block.
// Assumes the host model in etr_host and a shortened tick of 20 cycles.
`timescale 1ns/1ps
module tb_elapsed_time_event_recorder_regs;
    import etr_pkg::*;
    localparam int TICKS = 20;
    logic sys_clk;
    logic sys_rst;
    logic activity;
    logic [7:0] reg_addr;
    logic reg_wr_stb;
    logic [7:0] reg_wdata;
    logic reg_rd_stb;
    logic reg_stop;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic alert_oe;
    logic alert_out;
    int n_mismatch;
    int check_count;
    etr_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
        .reg_wdata(reg_wdata), .reg_rd_stb(reg_rd_stb), .reg_stop(reg_stop),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    etr_regs #(.TICK_CYCLES(TICKS)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .activity(activity), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
        .reg_wdata(reg_wdata), .reg_rd_stb(reg_rd_stb), .reg_stop(reg_stop),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alert_out(alert_out),
        .alert_oe(alert_oe));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd(a, d, ok);
        chk($sformatf("rvalid %h", a), 8'h01, {7'h00, ok});
        chk($sformatf("rdata %h", a), exp, d);
    endtask
    task automatic oe_chk(input logic exp);
        repeat (3) @(negedge sys_clk);
        chk("alert_oe", {7'h00, exp}, {7'h00, alert_oe});
        chk("alert_out", 8'h00, {7'h00, alert_out});
    endtask
    // A pin pulse shorter than FILT_CYC is swallowed by the filter. One of FILT_CYC or more is
    // accepted one filter time late on both edges, so the accepted high time equals hi.
    task automatic pulse(input int hi);
        @(negedge sys_clk);
        activity = 1'b1;
        repeat (hi) @(negedge sys_clk);
        activity = 1'b0;
        repeat (FILT_CYC + 10) @(negedge sys_clk);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_values();
        rchk(ADDR_CMD, 8'h00);
        rchk(ADDR_STAT, 8'h00);
        rchk(ADDR_PWA, 8'h00);
        rchk(8'h06, UNMAPPED_DATA);
        rchk(8'h30, UNMAPPED_DATA);
        rchk(ADDR_CFG, 8'h00);
        rchk(ADDR_ATC, 8'h00);
        $display("t_reset_values done");
    endtask
    task automatic t_password();
        host.wr(ADDR_UMEM, 8'ha5);
        rchk(ADDR_UMEM, 8'ha5);
        for (int i = 0; i < 4; i++) host.wr(ADDR_SPW + 8'(i), 8'h12 + 8'(i) * 8'h22);
        host.stp();
        rchk(ADDR_SPW, 8'h00);
        host.wr(ADDR_UMEM + 8'h01, 8'h5a);
        rchk(ADDR_UMEM + 8'h01, 8'h00);
        for (int i = 0; i < 3; i++) host.wr(ADDR_PWA + 8'(i), 8'h12 + 8'(i) * 8'h22);
        host.wr(ADDR_UMEM + 8'h01, 8'h5a);
        rchk(ADDR_UMEM + 8'h01, 8'h00);
        host.wr(ADDR_CFG, 8'h07);
        rchk(ADDR_CFG, 8'h00);
        host.wr(ADDR_PWA + 8'h03, 8'h78);
        host.wr(ADDR_UMEM + 8'h01, 8'h5a);
        rchk(ADDR_UMEM + 8'h01, 8'h5a);
        rchk(ADDR_PWA, 8'h00);
        $display("t_password done");
    endtask
    task automatic t_activity();
        @(negedge sys_clk);
        activity = 1'b1;
        repeat (FILT_CYC + 5) @(negedge sys_clk);
        rchk(ADDR_STAT, 8'h04);
        host.wr(ADDR_UMEM, 8'h00);
        repeat (80) @(negedge sys_clk);
        activity = 1'b0;
        repeat (FILT_CYC + 10) @(negedge sys_clk);
        rchk(ADDR_UMEM, 8'ha5);
        rchk(ADDR_FEC, 8'h01);
        rchk(ADDR_FEC + 8'h01, 8'h00);
        rchk(ADDR_ATC, 8'h0a);
        rchk(ADDR_ATC + 8'h01, 8'h00);
        rchk(ADDR_STAT, 8'h00);
        $display("t_activity done");
    endtask
    task automatic t_alert();
        host.wr(ADDR_CLIM, 8'h02);
        host.wr(ADDR_CFG, 8'hfa);
        rchk(ADDR_CFG, 8'h02);
        // Ten stored units plus seven 20-cycle ticks within 150 accepted high cycles.
        pulse(150);
        rchk(ADDR_FEC, 8'h02);
        rchk(ADDR_ATC, 8'h11);
        rchk(ADDR_STAT, 8'h02);
        oe_chk(1'b1);
        host.wr(ADDR_FEC, 8'h00);
        host.wr(ADDR_FEC + 8'h01, 8'h00);
        host.stp();
        rchk(ADDR_STAT, 8'h00);
        oe_chk(1'b1);
        host.wr(ADDR_CMD, 8'h01);
        oe_chk(1'b0);
        rchk(ADDR_CMD, 8'h00);
        host.wr(ADDR_FEC, 8'h05);
        host.stp();
        oe_chk(1'b1);
        host.wr(ADDR_CMD, 8'h01);
        oe_chk(1'b1);
        host.wr(ADDR_CFG, 8'h03);
        oe_chk(1'b0);
        host.wr(ADDR_TLIM, 8'h11);
        rchk(ADDR_STAT, 8'h03);
        host.wr(ADDR_TLIM, 8'h12);
        rchk(ADDR_STAT, 8'h02);
        $display("t_alert done");
    endtask
    task automatic t_saturate();
        pulse(FILT_CYC / 2);
        rchk(ADDR_FEC, 8'h05);
        host.wr(ADDR_FEC, 8'hff);
        host.wr(ADDR_FEC + 8'h01, 8'hff);
        host.stp();
        pulse(150);
        rchk(ADDR_FEC, 8'hff);
        rchk(ADDR_FEC + 8'h01, 8'hff);
        $display("t_saturate done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        n_mismatch = 0;
        check_count = 0;
        activity = 1'b0;
        sys_rst = 1'b1;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_reset_values();
        t_password();
        t_activity();
        t_alert();
        t_saturate();
        complete_run();
    end
endmodule // tb_elapsed_time_event_recorder_regs
